// >>> bench/fetch_model.sv
// fetch unit model: hands instruction bytes to the decoder
`timescale 1ns/1ps
module fetch_model (
  // clock
  input wire logic clk_in,
  // byte stream
  output logic valid_out,
  output logic [7:0] byte_out,
  output logic [15:0] addr_out
);
  logic [15:0] pc;
  initial
  begin
    valid_out = 1'b0;
    byte_out = 8'h00;
    addr_out = 16'h0000;
    pc = 16'h0000;
  end
  // byte held until the edge that takes it
  task automatic put(input logic [7:0] b);
    valid_out <= 1'b1;
    byte_out <= b;
    addr_out <= pc;
    pc = pc + 16'h0001;
    @(posedge clk_in);
  endtask
  // released bus shows inverted data so a stale byte never looks valid
  task automatic rel();
    valid_out <= 1'b0;
    byte_out <= ~byte_out;
  endtask
endmodule

// >>> bench/tb.sv
// self-checking bench for the operand field decoder
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic vld, done, simm, pol, wr;
  logic [7:0] byt, sv, dv, imm, vec, pair, sum;
  logic [15:0] bad, ib, dir, rl, idx;
  logic [3:0] wp, kind, wpair;
  logic [11:0] sa, da;
  logic [2:0] bitn;
  int err_count = 0;
  int compares = 0;
  always #25 clk = ~clk;
  fetch_model i_fetch (.clk_in(clk), .valid_out(vld), .byte_out(byt), .addr_out(bad));
  opdec_top i_dut (.CLK_IN(clk), .RST_IN(rst), .BYTE_VALID_IN(vld), .BYTE_IN(byt),
    .BYTE_ADDR_IN(bad), .WORK_PTR_IN(wp), .SRC_VALUE_IN(sv), .DST_VALUE_IN(dv),
    .INDEX_BASE_IN(ib), .DONE_OUT(done), .KIND_OUT(kind), .SRC_ADDR_OUT(sa),
    .DST_ADDR_OUT(da), .SRC_IS_IMM_OUT(simm), .IMM_OUT(imm), .BIT_NUM_OUT(bitn),
    .POLARITY_OUT(pol), .VECTOR_OUT(vec), .PAIR_ADDR_OUT(pair), .WORK_PAIR_OUT(wpair),
    .DIRECT_ADDR_OUT(dir), .REL_TARGET_OUT(rl), .INDEX_ADDR_OUT(idx), .WRITE_OUT(wr),
    .SUM_OUT(sum));
  task automatic chk(input logic [15:0] g, e);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic finish_test();
    $display("compares=%0d errors=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // one instruction; extended forms carry a fourth byte
  task automatic instr(input logic [7:0] op, b1, b2, b3, input logic ext,
    input logic [3:0] k, input logic [11:0] d);
    @(posedge clk);
    i_fetch.put(op);
    i_fetch.put(b1);
    i_fetch.put(b2);
    if (ext)
      i_fetch.put(b3);
    i_fetch.rel();
    #1;
    chk(16'(done), 16'h0001);
    chk(16'(kind), 16'(k));
    chk(16'(da), 16'(d));
    @(posedge clk);
    #1;
    chk(16'(wr), 16'(op == opdec_pkg::OPC_ADD_RR));
    if (op == opdec_pkg::OPC_ADD_RR)
      chk(16'(sum), 16'(8'(sv + dv)));
  endtask
  task automatic t_add();
    instr(8'h04, 8'h08, 8'h43, 8'h00, 1'b0, 4'd1, 12'h043);
    chk(16'(sa), 16'h0008);
    instr(8'h04, 8'hff, 8'h00, 8'h00, 1'b0, 4'd1, 12'h000);
    chk(16'(sa), 16'h00ff);
    @(posedge clk);
    wp <= 4'h3;
    // sum past 8 bits: carry must drop
    sv <= 8'h7f;
    dv <= 8'h81;
    instr(8'h04, 8'he8, 8'h43, 8'h00, 1'b0, 4'd1, 12'h043);
    chk(16'(sa), 16'h0038);
    @(posedge clk);
    sv <= 8'h12;
    dv <= 8'h34;
    instr(8'h04, 8'h43, 8'he5, 8'h00, 1'b0, 4'd1, 12'h035);
    chk(16'(sa), 16'h0043);
    $display("test add done");
  endtask
  task automatic t_ext();
    logic [7:0] rr [8] = '{8'h08, 8'h18, 8'h28, 8'h38, 8'ha8, 8'h1f, 8'h78, 8'h68};
    logic [3:0] kr [8] = '{4'd2, 4'd3, 4'd4, 4'd5, 4'd6, 4'd7, 4'd9, 4'd11};
    logic [11:0] d;
    for (int i = 0; i < 8; i++)
    begin
      d = 12'h001 + 12'(i);
      instr(rr[i], 8'hff, {4'hf, d[11:8]}, d[7:0], 1'b1, kr[i], d);
      chk(16'(sa), 16'h0fff);
      chk(16'(simm), 16'h0000);
      if (i < 6)
      begin
        // immediate forms sit one above their register forms, cpc sixteen above
        instr(rr[i] + 8'h01 + (i == 5 ? 8'h0f : 8'h00), 8'hf0 + 8'(i), 8'h5f, 8'hff,
          1'b1, kr[i], 12'hfff);
        chk(16'(imm), 16'(8'hf0 + 8'(i)));
        chk(16'(simm), 16'h0001);
      end
    end
    instr(8'h74, 8'h12, 8'h34, 8'h00, 1'b0, 4'd8, 12'h034);
    instr(8'h64, 8'h56, 8'h78, 8'h00, 1'b0, 4'd10, 12'h078);
    $display("test extended done");
  endtask
  task automatic t_fields();
    @(posedge clk);
    i_fetch.pc = 16'h1000;
    ib <= 16'h2000;
    i_fetch.put(8'h04);
    i_fetch.put(8'h80);
    i_fetch.rel();
    #1;
    // displacement is the held first operand byte, still 56 from the last test
    chk(rl, 16'h1058);
    chk(idx, 16'h1f80);
    chk(16'(bitn), 16'h0000);
    chk(16'(pol), 16'h0000);
    chk(16'(pair), 16'h0080);
    @(posedge clk);
    i_fetch.put(8'h7f);
    i_fetch.rel();
    #1;
    chk(dir, 16'h807f);
    chk(rl, 16'h0f83);
    chk(idx, 16'h207f);
    chk(16'(bitn), 16'h0007);
    chk(16'(pol), 16'h0001);
    chk(16'(vec), 16'h007f);
    chk(16'(pair), 16'h007e);
    chk(16'(wpair), 16'h000e);
    $display("test fields done");
  endtask
  task automatic t_unknown();
    @(posedge clk);
    i_fetch.put(8'hff);
    i_fetch.put(8'h01);
    i_fetch.put(8'h02);
    i_fetch.rel();
    repeat (4)
    begin
      #1;
      chk(16'(done), 16'h0000);
      @(posedge clk);
    end
    $display("test unknown done");
  endtask
  initial
  begin
    wp = 4'h0;
    sv = 8'hf0;
    dv = 8'h25;
    ib = 16'h0000;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(16'(done), 16'h0000);
    chk(16'(kind), 16'h0000);
    t_add();
    t_ext();
    t_fields();
    t_unknown();
    finish_test();
  end
  initial
  begin
    #200000;
    err_count++;
    finish_test();
  end
endmodule

// >>> rtl/opdec_field.sv
// combinational helpers for single operand fields
`timescale 1ns/1ps
module opdec_field (
  input wire logic [7:0] reg_field_in,
  input wire logic [3:0] work_ptr_in,
  input wire logic [7:0] disp_in,
  input wire logic [15:0] base_in,
  output logic [7:0] reg_addr_out,
  output logic [15:0] target_out
);
  // escaped field names a working register inside the pointed group
  always_comb
  begin
    if (reg_field_in[7:4] == opdec_pkg::WORK_ESCAPE)
      reg_addr_out = {work_ptr_in, reg_field_in[3:0]}; // [RL2]
    else
      reg_addr_out = reg_field_in; // [RL2]
  end
  // sign-extended displacement, wraps around the 64K space
  assign target_out = base_in + {{8{disp_in[7]}}, disp_in}; // [RL9] [RL10]
endmodule

// >>> rtl/opdec_pkg.sv
// constants for the operand field decoder
package opdec_pkg;
  // opcodes of the register-addressed arithmetic and mask-test groups
  localparam logic [7:0] OPC_ADD_RR = 8'h04;
  localparam logic [7:0] OPC_ADD_EXT_RR = 8'h08;
  localparam logic [7:0] OPC_ADD_EXT_IM = 8'h09;
  localparam logic [7:0] OPC_ADC_EXT_RR = 8'h18;
  localparam logic [7:0] OPC_ADC_EXT_IM = 8'h19;
  localparam logic [7:0] OPC_SUB_EXT_RR = 8'h28;
  localparam logic [7:0] OPC_SUB_EXT_IM = 8'h29;
  localparam logic [7:0] OPC_SBC_EXT_RR = 8'h38;
  localparam logic [7:0] OPC_SBC_EXT_IM = 8'h39;
  localparam logic [7:0] OPC_CP_EXT_RR = 8'ha8;
  localparam logic [7:0] OPC_CP_EXT_IM = 8'ha9;
  localparam logic [7:0] OPC_CPC_EXT_RR = 8'h1f;
  localparam logic [7:0] OPC_CPC_EXT_IM = 8'h2f;
  localparam logic [7:0] OPC_TM_RR = 8'h74;
  localparam logic [7:0] OPC_TM_EXT_RR = 8'h78;
  localparam logic [7:0] OPC_TCM_RR = 8'h64;
  localparam logic [7:0] OPC_TCM_EXT_RR = 8'h68;
  // escape marker of a working register in an 8-bit register field
  localparam logic [3:0] WORK_ESCAPE = 4'he;
  localparam logic [7:0] PAIR_MASK = 8'hfe;
  localparam logic [2:0] BIT_MAX = 3'h7;

  typedef enum logic [3:0] {
    op_none,
    add_op,
    add_ext_op,
    add_with_carry_ext_op,
    subtract_ext_op,
    subtract_with_carry_ext_op,
    compare_ext_op,
    compare_with_carry_ext_op,
    mask_test_op,
    mask_test_ext_op,
    complement_mask_test_op,
    complement_mask_test_ext_op
  } op_kind_e;
endpackage

// >>> rtl/opdec_top.sv
// operand field decoder: collects opcode bytes and splits the operand fields
// How it works
// RL1: for register add, byte after opcode is source, next byte destination.
// RL2: 8-bit register field selects 0-255; upper nibble E selects a working register.
// RL3: bit-number operand is three bits, bit 0 to 7.
// RL4: direct address is a full 16-bit program address.
// RL5: extended register operand is a 12-bit address 000 to FFF.
// RL6: immediate data is one byte straight from the instruction stream.
// RL7: working pair operand names even pairs 0 to 14 only.
// RL8: register pair is an even location 00-FE plus the next one.
// RL9: relative displacement is signed 8-bit, added to next instruction address.
// RL10: index is signed 8-bit, added to the indexed register contents.
// RL11: trap vector is an 8-bit value 00 to FF.
// RL12: polarity is one bit, choosing clear/set or test for zero/one.
// RL13: add sums source and destination, result goes to destination.
// RL14: extended-address variants of add, adc, cp, cpc, sub, sbc are decoded.
// RL15: mask test, true and complemented, normal and extended, are decoded.
// RL16: out-of-range field values are undefined, never raise an exception.
`timescale 1ns/1ps
module opdec_top (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // instruction byte stream from fetch, and the working register pointer
  input wire logic BYTE_VALID_IN,
  input wire logic [7:0] BYTE_IN,
  input wire logic [15:0] BYTE_ADDR_IN,
  input wire logic [3:0] WORK_PTR_IN,
  // add datapath and index base: operand values read by the executor
  input wire logic [7:0] SRC_VALUE_IN,
  input wire logic [7:0] DST_VALUE_IN,
  input wire logic [15:0] INDEX_BASE_IN,
  // decoded instruction
  output logic DONE_OUT,
  output logic [3:0] KIND_OUT,
  output logic [11:0] SRC_ADDR_OUT,
  output logic [11:0] DST_ADDR_OUT,
  output logic SRC_IS_IMM_OUT,
  output logic [7:0] IMM_OUT,
  // generic field views of each operand byte
  output logic [2:0] BIT_NUM_OUT,
  output logic POLARITY_OUT,
  output logic [7:0] VECTOR_OUT,
  output logic [7:0] PAIR_ADDR_OUT,
  output logic [3:0] WORK_PAIR_OUT,
  output logic [15:0] DIRECT_ADDR_OUT,
  output logic [15:0] REL_TARGET_OUT,
  output logic [15:0] INDEX_ADDR_OUT,
  // add result written back to destination
  output logic WRITE_OUT,
  output logic [7:0] SUM_OUT
);
  typedef enum logic [2:0] {st_op, st_b1, st_b2, st_b3} phase_e;
  phase_e phase_reg;
  opdec_pkg::op_kind_e kind_reg;
  logic [7:0] op_reg;
  logic [7:0] b1_reg;
  logic [7:0] b2_reg;
  logic [7:0] reg_addr;
  logic [7:0] dst_addr;
  logic [15:0] rel_target;
  logic [15:0] idx_target;
  logic last;
  logic is_ext;
  logic is_imm;

  // register field through escape decode, target of a relative jump
  opdec_field u_src (
    .reg_field_in(b1_reg),
    .work_ptr_in(WORK_PTR_IN),
    .disp_in(b1_reg),
    .base_in(BYTE_ADDR_IN + 16'h0001),
    .reg_addr_out(reg_addr),
    .target_out(rel_target)
  );
  opdec_field u_dst (
    .reg_field_in(BYTE_IN),
    .work_ptr_in(WORK_PTR_IN),
    .disp_in(BYTE_IN),
    .base_in(INDEX_BASE_IN),
    .reg_addr_out(dst_addr),
    .target_out(idx_target)
  );

  function automatic opdec_pkg::op_kind_e kind_of(input logic [7:0] op);
    case (op)
      opdec_pkg::OPC_ADD_RR: kind_of = opdec_pkg::add_op;
      opdec_pkg::OPC_ADD_EXT_RR, opdec_pkg::OPC_ADD_EXT_IM: kind_of = opdec_pkg::add_ext_op;
      opdec_pkg::OPC_ADC_EXT_RR, opdec_pkg::OPC_ADC_EXT_IM:
        kind_of = opdec_pkg::add_with_carry_ext_op; // [RL14]
      opdec_pkg::OPC_SUB_EXT_RR, opdec_pkg::OPC_SUB_EXT_IM: kind_of = opdec_pkg::subtract_ext_op;
      opdec_pkg::OPC_SBC_EXT_RR, opdec_pkg::OPC_SBC_EXT_IM:
        kind_of = opdec_pkg::subtract_with_carry_ext_op;
      opdec_pkg::OPC_CP_EXT_RR, opdec_pkg::OPC_CP_EXT_IM: kind_of = opdec_pkg::compare_ext_op;
      opdec_pkg::OPC_CPC_EXT_RR, opdec_pkg::OPC_CPC_EXT_IM:
        kind_of = opdec_pkg::compare_with_carry_ext_op;
      opdec_pkg::OPC_TM_RR: kind_of = opdec_pkg::mask_test_op; // [RL15]
      opdec_pkg::OPC_TM_EXT_RR: kind_of = opdec_pkg::mask_test_ext_op;
      opdec_pkg::OPC_TCM_RR: kind_of = opdec_pkg::complement_mask_test_op;
      opdec_pkg::OPC_TCM_EXT_RR: kind_of = opdec_pkg::complement_mask_test_ext_op;
      default: kind_of = opdec_pkg::op_none; // [RL16]
    endcase
  endfunction

  assign is_ext = (kind_reg != opdec_pkg::op_none) && (kind_reg != opdec_pkg::add_op)
    && (kind_reg != opdec_pkg::mask_test_op) && (kind_reg != opdec_pkg::complement_mask_test_op);
  // normal forms take two operand bytes, extended forms three
  assign last = (phase_reg == st_b2 && !is_ext) || phase_reg == st_b3;
  // immediate forms told apart by opcode, one of them sits sixteen above an odd register-form code
  assign is_imm = op_reg == opdec_pkg::OPC_ADD_EXT_IM || op_reg == opdec_pkg::OPC_ADC_EXT_IM
    || op_reg == opdec_pkg::OPC_SUB_EXT_IM || op_reg == opdec_pkg::OPC_SBC_EXT_IM
    || op_reg == opdec_pkg::OPC_CP_EXT_IM || op_reg == opdec_pkg::OPC_CPC_EXT_IM;

  // byte collection
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      phase_reg <= st_op;
      kind_reg <= opdec_pkg::op_none;
      op_reg <= 8'h00;
      b1_reg <= 8'h00;
      b2_reg <= 8'h00;
    end
    else if (BYTE_VALID_IN)
    begin
      case (phase_reg)
        st_op:
        begin
          op_reg <= BYTE_IN;
          kind_reg <= kind_of(BYTE_IN);
          // unknown opcodes are ignored, the decoder stays idle
          if (kind_of(BYTE_IN) != opdec_pkg::op_none)
            phase_reg <= st_b1;
        end
        st_b1:
        begin
          b1_reg <= BYTE_IN;
          phase_reg <= st_b2;
        end
        st_b2:
        begin
          b2_reg <= BYTE_IN;
          phase_reg <= is_ext ? st_b3 : st_op;
        end
        default:
          phase_reg <= st_op;
      endcase
    end
  end

  // decoded operand outputs
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      DONE_OUT <= 1'b0;
      KIND_OUT <= 4'h0;
      SRC_ADDR_OUT <= 12'h000;
      DST_ADDR_OUT <= 12'h000;
      SRC_IS_IMM_OUT <= 1'b0;
      IMM_OUT <= 8'h00;
    end
    else
    begin
      DONE_OUT <= BYTE_VALID_IN && last;
      if (BYTE_VALID_IN && last)
      begin
        KIND_OUT <= kind_reg;
        if (!is_ext)
        begin
          SRC_ADDR_OUT <= {4'h0, reg_addr}; // [RL1] [RL2]
          DST_ADDR_OUT <= {4'h0, dst_addr}; // [RL1] [RL2]
          SRC_IS_IMM_OUT <= 1'b0;
        end
        else if (is_imm)
        begin
          // immediate form: src byte, then 12-bit dst in two bytes
          SRC_IS_IMM_OUT <= 1'b1;
          IMM_OUT <= b1_reg; // [RL6]
          DST_ADDR_OUT <= {b2_reg[3:0], BYTE_IN}; // [RL5]
        end
        else
        begin
          SRC_IS_IMM_OUT <= 1'b0;
          SRC_ADDR_OUT <= {b1_reg, b2_reg[7:4]}; // [RL5]
          DST_ADDR_OUT <= {b2_reg[3:0], BYTE_IN}; // [RL5]
        end
      end
    end
  end

  // generic field views of each operand byte
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      BIT_NUM_OUT <= 3'h0;
      POLARITY_OUT <= 1'b0;
      VECTOR_OUT <= 8'h00;
      PAIR_ADDR_OUT <= 8'h00;
      WORK_PAIR_OUT <= 4'h0;
      DIRECT_ADDR_OUT <= 16'h0000;
      REL_TARGET_OUT <= 16'h0000;
      INDEX_ADDR_OUT <= 16'h0000;
    end
    else if (BYTE_VALID_IN && phase_reg != st_op)
    begin
      BIT_NUM_OUT <= BYTE_IN[3:1] & opdec_pkg::BIT_MAX; // [RL3]
      POLARITY_OUT <= BYTE_IN[0]; // [RL12]
      VECTOR_OUT <= BYTE_IN; // [RL11]
      PAIR_ADDR_OUT <= BYTE_IN & opdec_pkg::PAIR_MASK; // [RL8] [RL16]
      WORK_PAIR_OUT <= {BYTE_IN[3:1], 1'b0}; // [RL7]
      DIRECT_ADDR_OUT <= {b1_reg, BYTE_IN}; // [RL4]
      REL_TARGET_OUT <= rel_target; // [RL9]
      INDEX_ADDR_OUT <= idx_target; // [RL10]
    end
  end

  // add write-back one cycle after decode
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      WRITE_OUT <= 1'b0;
      SUM_OUT <= 8'h00;
    end
    else
    begin
      WRITE_OUT <= DONE_OUT && (KIND_OUT == 4'(opdec_pkg::add_op)); // [RL13]
      SUM_OUT <= SRC_VALUE_IN + DST_VALUE_IN; // [RL13]
    end
  end

  property p_add_order;
    @(posedge CLK_IN) disable iff (RST_IN)
    (BYTE_VALID_IN && last && kind_reg == opdec_pkg::add_op)
      |=> (DST_ADDR_OUT[7:0] == $past(dst_addr) && SRC_ADDR_OUT[7:0] == $past(reg_addr));
  endproperty
  a_add_order: assert property (p_add_order) else $error("add operand order wrong"); // [RL1]

  property p_escape;
    @(posedge CLK_IN) disable iff (RST_IN)
    (BYTE_VALID_IN && last && !is_ext && b1_reg[7:4] == opdec_pkg::WORK_ESCAPE)
      |=> SRC_ADDR_OUT[7:0] == {$past(WORK_PTR_IN), $past(b1_reg[3:0])};
  endproperty
  a_escape: assert property (p_escape) else $error("escape decode wrong"); // [RL2]

  property p_pair_even;
    @(posedge CLK_IN) disable iff (RST_IN)
    (BYTE_VALID_IN && phase_reg != st_op) |=> (PAIR_ADDR_OUT == {$past(BYTE_IN[7:1]), 1'b0}
      && WORK_PAIR_OUT == {$past(BYTE_IN[3:1]), 1'b0});
  endproperty
  a_pair_even: assert property (p_pair_even) else $error("pair not even"); // [RL7]

  property p_rel;
    @(posedge CLK_IN) disable iff (RST_IN)
    (BYTE_VALID_IN && phase_reg != st_op) |=> REL_TARGET_OUT ==
      $past(BYTE_ADDR_IN) + 16'h0001 + {{8{$past(b1_reg[7])}}, $past(b1_reg)};
  endproperty
  a_rel: assert property (p_rel) else $error("relative target wrong"); // [RL9]

  property p_index;
    @(posedge CLK_IN) disable iff (RST_IN)
    (BYTE_VALID_IN && phase_reg != st_op) |=> INDEX_ADDR_OUT ==
      $past(INDEX_BASE_IN) + {{8{$past(BYTE_IN[7])}}, $past(BYTE_IN)};
  endproperty
  a_index: assert property (p_index) else $error("index target wrong"); // [RL10]

  sequence s_add_done;
    DONE_OUT && KIND_OUT == 4'(opdec_pkg::add_op);
  endsequence
  property p_add_write;
    @(posedge CLK_IN) disable iff (RST_IN)
    s_add_done |=> WRITE_OUT ##0 (SUM_OUT == $past(SRC_VALUE_IN) + $past(DST_VALUE_IN));
  endproperty
  a_add_write: assert property (p_add_write) else $error("add write-back wrong"); // [RL13]

  property p_ext_len;
    @(posedge CLK_IN) disable iff (RST_IN)
    (BYTE_VALID_IN && phase_reg == st_b2 && is_ext) |=> !DONE_OUT;
  endproperty
  a_ext_len: assert property (p_ext_len) else $error("extended form ended early"); // [RL14]

  property p_direct;
    @(posedge CLK_IN) disable iff (RST_IN)
    (BYTE_VALID_IN && phase_reg != st_op) |=> DIRECT_ADDR_OUT ==
      {$past(b1_reg), $past(BYTE_IN)};
  endproperty
  a_direct: assert property (p_direct) else $error("direct address wrong"); // [RL4]
endmodule
